//--- pfa_ctrl.sv
/*
  program flash self-access controller: address, data and control
  registers on an Avalon-MM slave, read and write engine toward the
  memory array, unlock sequence, core stall and interrupt status.
  assumes the array answers a read within two cycles and pulses
  mem_write_done once a write is finished; write protect is a static strap.
*/
// Behaviour
// - read takes two cycles, data then valid
// - fetched word loads high and low data
// - data registers hold until read or write
// - select bit routes access to program memory
// - core stalls while program write runs
// - execution resumes once the write reports done
// - cleared write protect blocks program writes
// - address, data, select, enable set before write
// - write start needs enable set earlier
// - clearing enable never aborts running write
// - uninterrupted three-step unlock (two keys, then start) precedes each write
// - two preparation cycles precede the stall
// - control bit layout, unused bits zero
module pfa_ctrl (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] mem_addr,
  output logic [13:0] mem_wdata,
  input wire logic [13:0] mem_rdata,
  output logic prog_rd_req,
  output logic data_rd_req,
  output logic prog_wr_req,
  output logic data_wr_req,
  input wire logic mem_write_done,
  input wire logic program_write_protect_cfg,
  input wire logic core_irq_entry,
  output logic core_stall,
  output logic irq
);
  logic [7:0] data_low;
  logic [7:0] data_high;
  logic [7:0] addr_low;
  logic [7:0] addr_high;
  logic ctl_sel;
  logic ctl_err;
  logic ctl_write_enable_gate;
  logic ctl_wr;
  logic ctl_rd;
  logic wr_sel;
  logic [pfa_pkg::EV_W-1:0] irq_status;
  logic [pfa_pkg::EV_W-1:0] irq_enable;
  logic wp_s1;
  logic wp_s2;
  logic wp_s3;
  logic wp_ok;
  logic [pfa_pkg::CNT_W-1:0] cnt;
  pfa_pkg::pfa_eng_t eng;
  pfa_pkg::pfa_ul_t ul;
  logic [9:0] idx;
  logic acc;
  logic wr_acc;
  logic ctl_wr_acc;
  logic start_rd;
  logic wr_try;
  logic start_wr;
  logic rd_last;
  logic wr_done_ev;
  logic [pfa_pkg::EV_W-1:0] events;
  logic [7:0] wd;
  logic rst_q;

  // register index from a byte address
  function automatic logic [9:0] reg_index(input logic [11:0] a);
    return a[11:2];
  endfunction

  // read value of one register, zero for unmapped or write-only
  function automatic logic [7:0] reg_value(input logic [9:0] i);
    logic [7:0] v;
    v = pfa_pkg::BYTE_ZERO;
    unique case (i)
      pfa_pkg::IDX_DATA_LOW: v = data_low;
      pfa_pkg::IDX_DATA_HIGH: v = data_high;
      pfa_pkg::IDX_ADDR_LOW: v = addr_low;
      pfa_pkg::IDX_ADDR_HIGH: v = addr_high;
      pfa_pkg::IDX_CONTROL: begin
        v[pfa_pkg::CTL_SEL_BIT] = ctl_sel;
        v[pfa_pkg::CTL_ERR_BIT] = ctl_err;
        v[pfa_pkg::CTL_WRITE_ENABLE_GATE_BIT] = ctl_write_enable_gate;
        v[pfa_pkg::CTL_WR_BIT] = ctl_wr;
        v[pfa_pkg::CTL_RD_BIT] = ctl_rd;
      end
      pfa_pkg::IDX_IRQ_STATUS: v[pfa_pkg::EV_W-1:0] = irq_status;
      pfa_pkg::IDX_IRQ_ENABLE: v[pfa_pkg::EV_W-1:0] = irq_enable;
      default: v = pfa_pkg::BYTE_ZERO; // unlock port reads zero
    endcase
    return v;
  endfunction

  // bus decode and operation starts
  assign idx = reg_index(avs_address);
  assign wd = avs_writedata[7:0];
  assign acc = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_acc = avs_write && !avs_waitrequest;
  assign ctl_wr_acc = wr_acc && (idx == pfa_pkg::IDX_CONTROL);
  assign rd_last = (eng == pfa_pkg::ST_READ) && (cnt == pfa_pkg::CNT_ZERO);
  assign wr_done_ev = (eng == pfa_pkg::ST_WRITE) && mem_write_done;
  assign wr_try = ctl_wr_acc && wd[pfa_pkg::CTL_WR_BIT] && !ctl_wr;
  // enable must already stand before this write, unlock armed, no protect
  assign start_wr = wr_try && ctl_write_enable_gate && (ul == pfa_pkg::UL_ARMED)
    && (eng == pfa_pkg::ST_IDLE)
    && (!wd[pfa_pkg::CTL_SEL_BIT] || wp_ok);
  assign start_rd = ctl_wr_acc && wd[pfa_pkg::CTL_RD_BIT] && !wr_try
    && (eng == pfa_pkg::ST_IDLE);
  assign events[pfa_pkg::EV_RD_DONE] = rd_last;
  assign events[pfa_pkg::EV_WR_DONE] = wr_done_ev;
  assign events[pfa_pkg::EV_WR_REFUSED] = wr_try && !start_wr;
  assign mem_addr = {addr_high, addr_low};
  assign mem_wdata = {data_high[pfa_pkg::HIGH_W-1:0], data_low};

  // avalon slave: one wait cycle, then accept with read data ready
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= pfa_pkg::WORD_ZERO;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, reg_value(idx)};
      end
    end
  end

  // write protect strap through three flops, taken when last two agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
      wp_s3 <= 1'b0;
      wp_ok <= 1'b0;
    end else begin
      wp_s1 <= program_write_protect_cfg;
      wp_s2 <= wp_s1;
      wp_s3 <= wp_s2;
      if (wp_s2 == wp_s3) begin
        wp_ok <= wp_s3;
      end
    end
  end

  // address registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_low <= pfa_pkg::BYTE_ZERO;
      addr_high <= pfa_pkg::BYTE_ZERO;
    end else if (wr_acc) begin
      if (idx == pfa_pkg::IDX_ADDR_LOW) addr_low <= wd;
      if (idx == pfa_pkg::IDX_ADDR_HIGH) addr_high <= wd;
    end
  end

  // data registers: loaded by a finished read or by firmware, else held
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_low <= pfa_pkg::BYTE_ZERO;
      data_high <= pfa_pkg::BYTE_ZERO;
    end else if (rd_last) begin
      data_low <= mem_rdata[7:0];
      data_high <= {2'h0, mem_rdata[pfa_pkg::WORD_W-1:8]};
    end else if (wr_acc) begin
      if (idx == pfa_pkg::IDX_DATA_LOW) data_low <= wd;
      if (idx == pfa_pkg::IDX_DATA_HIGH) data_high <= wd;
    end
  end

  // reset level one edge ago, so a long reset keeps what its first edge saw
  always_ff @(posedge core_clk) begin
    rst_q <= reset;
  end

  // control register; a reset during a write leaves the error flag set
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctl_sel <= 1'b0;
      ctl_write_enable_gate <= 1'b0;
      ctl_wr <= 1'b0;
      ctl_rd <= 1'b0;
      if (rst_q) begin
        ctl_err <= ctl_err; // later reset edges keep the first edge's verdict
      end else if ((eng == pfa_pkg::ST_WPREP) || (eng == pfa_pkg::ST_WRITE)) begin
        ctl_err <= 1'b1; // write cut short by reset
      end else begin
        ctl_err <= 1'b0;
      end
    end else begin
      if (ctl_wr_acc) begin
        ctl_sel <= wd[pfa_pkg::CTL_SEL_BIT];
        ctl_write_enable_gate <= wd[pfa_pkg::CTL_WRITE_ENABLE_GATE_BIT]; // engine ignores it later
        if (!wd[pfa_pkg::CTL_ERR_BIT]) ctl_err <= 1'b0;
      end
      if (start_rd) ctl_rd <= 1'b1;
      else if (rd_last) ctl_rd <= 1'b0;
      if (start_wr) ctl_wr <= 1'b1;
      else if (wr_done_ev) ctl_wr <= 1'b0;
    end
  end

  // unlock sequence; any other access or an interrupt entry breaks it
  always_ff @(posedge core_clk) begin
    if (reset || core_irq_entry) begin
      ul <= pfa_pkg::UL_NONE;
    end else if (acc) begin
      if (wr_acc && idx == pfa_pkg::IDX_UNLOCK && wd == pfa_pkg::UNLOCK_KEY1) begin
        ul <= pfa_pkg::UL_FIRST;
      end else if (wr_acc && idx == pfa_pkg::IDX_UNLOCK && wd == pfa_pkg::UNLOCK_KEY2
                   && ul == pfa_pkg::UL_FIRST) begin
        ul <= pfa_pkg::UL_ARMED;
      end else begin
        ul <= pfa_pkg::UL_NONE;
      end
    end
  end

  // read and write engine toward the memory array
  always_ff @(posedge core_clk) begin
    if (reset) begin
      eng <= pfa_pkg::ST_IDLE;
      cnt <= pfa_pkg::CNT_ZERO;
      wr_sel <= 1'b0;
      prog_rd_req <= 1'b0;
      data_rd_req <= 1'b0;
      prog_wr_req <= 1'b0;
      data_wr_req <= 1'b0;
      core_stall <= 1'b0;
    end else begin
      unique case (eng)
        pfa_pkg::ST_IDLE: begin
          if (start_rd) begin
            eng <= pfa_pkg::ST_READ;
            cnt <= pfa_pkg::CNT_W'(pfa_pkg::READ_CYCLES - 1);
            prog_rd_req <= wd[pfa_pkg::CTL_SEL_BIT];
            data_rd_req <= !wd[pfa_pkg::CTL_SEL_BIT];
          end else if (start_wr) begin
            eng <= pfa_pkg::ST_WPREP;
            cnt <= pfa_pkg::CNT_W'(pfa_pkg::PREP_CYCLES - 1);
            wr_sel <= wd[pfa_pkg::CTL_SEL_BIT];
          end
        end
        pfa_pkg::ST_READ: begin
          if (cnt == pfa_pkg::CNT_ZERO) begin
            eng <= pfa_pkg::ST_IDLE;
            prog_rd_req <= 1'b0;
            data_rd_req <= 1'b0;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        pfa_pkg::ST_WPREP: begin
          if (cnt == pfa_pkg::CNT_ZERO) begin
            eng <= pfa_pkg::ST_WRITE;
            prog_wr_req <= wr_sel;
            data_wr_req <= !wr_sel;
            core_stall <= wr_sel; // only program writes halt the core
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        pfa_pkg::ST_WRITE: begin
          prog_wr_req <= 1'b0;
          data_wr_req <= 1'b0;
          if (mem_write_done) begin
            eng <= pfa_pkg::ST_IDLE;
            core_stall <= 1'b0; // core goes on once the array reports the write done
          end
        end
      endcase
    end
  end

  // interrupt status, enable and clear; a new event wins over its clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_acc && idx == pfa_pkg::IDX_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~wd[pfa_pkg::EV_W-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      if (wr_acc && idx == pfa_pkg::IDX_IRQ_ENABLE) irq_enable <= wd[pfa_pkg::EV_W-1:0];
      irq <= |(irq_status & irq_enable);
    end
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_read_start;
    start_rd;
  endsequence
  sequence s_write_start;
    start_wr && wd[pfa_pkg::CTL_SEL_BIT];
  endsequence

  AST_READ_TWO_CYCLES: assert property (s_read_start |=> ctl_rd [*2] ##1 !ctl_rd)
    else $error("read did not take two cycles");
  AST_DATA_LOAD: assert property (rd_last |=> {data_high[pfa_pkg::HIGH_W-1:0], data_low}
    == $past(mem_rdata))
    else $error("fetched word not loaded");
  AST_DATA_HOLD: assert property (!rd_last && !wr_acc |=> $stable(data_low)
    && $stable(data_high))
    else $error("data registers changed without cause");
  AST_ROUTE: assert property ((prog_rd_req || prog_wr_req) |-> !data_rd_req && !data_wr_req
    && (prog_rd_req ? ctl_sel : wr_sel))
    else $error("access routed to wrong memory");
  AST_STALL_AFTER_PREP: assert property (s_write_start |=> !core_stall [*2] ##1 core_stall)
    else $error("stall not after two preparation cycles");
  AST_STALL_HOLD: assert property (core_stall && !mem_write_done |=> core_stall)
    else $error("stall dropped before write end");
  AST_RESUME: assert property (core_stall && mem_write_done |=> !core_stall)
    else $error("core not resumed after write");
  AST_PROTECT: assert property (prog_wr_req |-> $past(wp_ok, 3))
    else $error("program write while protected");
  AST_SAME_OP: assert property (ctl_wr_acc && !ctl_write_enable_gate |=> !ctl_wr)
    else $error("write started with enable in same op");
  AST_NO_ABORT: assert property ((eng == pfa_pkg::ST_WRITE) && !mem_write_done
    |=> eng == pfa_pkg::ST_WRITE)
    else $error("running write cut short");
  AST_UNLOCK: assert property (start_wr |-> $past(ul == pfa_pkg::UL_FIRST)
    || ul == pfa_pkg::UL_ARMED)
    else $error("write without unlock sequence");
  AST_UNLOCK_READS_ZERO: assert property (avs_read && avs_waitrequest
    && idx == pfa_pkg::IDX_UNLOCK |=> avs_readdata == pfa_pkg::WORD_ZERO)
    else $error("unlock port returned data");
  AST_CTL_RESERVED: assert property (avs_read && avs_waitrequest && idx == pfa_pkg::IDX_CONTROL
    |=> avs_readdata[6:4] == 3'h0)
    else $error("unused control bits not zero");
  AST_WR_CLEARED: assert property (wr_done_ev |=> !ctl_wr)
    else $error("write start bit not cleared");
endmodule

//--- pfa_flash_model.sv
/*
  behavioural program flash array facing pfa_ctrl: sixteen preset rows,
  slow program writes ending in a done pulse, and a data-space answer.
  assumes requests come registered on core_clk from pfa_ctrl.
*/
module pfa_flash_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] mem_addr,
  input wire logic [13:0] mem_wdata,
  input wire logic prog_rd_req,
  input wire logic data_rd_req,
  input wire logic prog_wr_req,
  input wire logic data_wr_req,
  output logic [13:0] mem_rdata,
  output logic mem_write_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] cells [16];
  logic [3:0] busy_cnt;
  logic [13:0] idle_pat;
  // answer only while a read stands; otherwise a pattern that keeps changing
  always_comb begin
    mem_rdata = idle_pat;
    if (prog_rd_req) begin
      mem_rdata = cells[mem_addr[3:0]];
    end else if (data_rd_req) begin
      mem_rdata = 14'h0bcd;
    end
  end
  // a program write is stored at once, and any write is reported done eight cycles later;
  // reset presets each row with a pattern carrying its own index
  always_ff @(posedge core_clk) begin
    idle_pat <= ~idle_pat;
    mem_write_done <= 1'b0;
    if (reset) begin
      busy_cnt <= 4'h0;
      idle_pat <= 14'h1555;
      for (int i = 0; i < 16; i++) begin
        cells[i] <= 14'h3a50 | 14'(i);
      end
    end else if (prog_wr_req || data_wr_req) begin
      busy_cnt <= 4'h8;
      if (prog_wr_req) begin
        cells[mem_addr[3:0]] <= mem_wdata;
      end
    end else if (busy_cnt != 4'h0) begin
      busy_cnt <= busy_cnt - 4'h1;
      mem_write_done <= (busy_cnt == 4'h1);
    end
  end
endmodule

//--- pfa_pkg.sv
/*
  constants, register indices, field positions and types shared by the
  program flash self-access controller.
  assumes one instruction clock of 40 MHz and an Avalon-MM register bus.
*/
package pfa_pkg;
  // register indices; byte address is four times the index
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_DATA_LOW = 10'h10c;
  localparam logic [9:0] IDX_ADDR_LOW = 10'h10d;
  localparam logic [9:0] IDX_DATA_HIGH = 10'h10e;
  localparam logic [9:0] IDX_ADDR_HIGH = 10'h10f;
  localparam logic [9:0] IDX_CONTROL = 10'h18c;
  localparam logic [9:0] IDX_UNLOCK = 10'h18d;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h190;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h191;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h192;
  // control register fields
  localparam int CTL_SEL_BIT = 7;
  localparam int CTL_ERR_BIT = 3;
  localparam int CTL_WRITE_ENABLE_GATE_BIT = 2;
  localparam int CTL_WR_BIT = 1;
  localparam int CTL_RD_BIT = 0;
  // interrupt event bits
  localparam int EV_W = 3;
  localparam int EV_RD_DONE = 0;
  localparam int EV_WR_DONE = 1;
  localparam int EV_WR_REFUSED = 2;
  // word and address geometry
  localparam int WORD_W = 14;
  localparam int HIGH_W = 6;
  localparam int ADDR_W = 16;
  // unlock keys written to the unlock port
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  // timing: one core clock is one instruction cycle
  localparam int CLK_PERIOD_NS = 25;
  localparam int INSN_NS = 25;
  localparam int READ_INSNS = 2;
  localparam int PREP_INSNS = 2;
  localparam int READ_CYCLES = (READ_INSNS * INSN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREP_CYCLES = (PREP_INSNS * INSN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 2;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WPREP, ST_WRITE} pfa_eng_t;
  typedef enum logic [1:0] {UL_NONE, UL_FIRST, UL_ARMED} pfa_ul_t;
endpackage

//--- program_flash_self_access_tb.sv
/*
  self-checking bench for pfa_ctrl: Avalon register accesses, flash reads,
  guarded writes, refusals, interrupts and reset in mid-write.
  assumes pfa_flash_model on the far side and a 40 MHz core clock.
*/
module program_flash_self_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [15:0] mem_addr;
  logic [13:0] mem_wdata, mem_rdata;
  logic prog_rd_req, data_rd_req, prog_wr_req, data_wr_req, mem_write_done;
  logic program_write_protect_cfg, core_irq_entry, core_stall, irq;
  int err_count = 0;
  int tests_run = 0;
  pfa_ctrl pfa_ctrl_inst (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .prog_rd_req(prog_rd_req),
    .data_rd_req(data_rd_req), .prog_wr_req(prog_wr_req), .data_wr_req(data_wr_req),
    .mem_write_done(mem_write_done), .program_write_protect_cfg(program_write_protect_cfg),
    .core_irq_entry(core_irq_entry), .core_stall(core_stall), .irq(irq));
  pfa_flash_model pfa_flash_model_inst (.core_clk(core_clk), .reset(reset),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .prog_rd_req(prog_rd_req),
    .data_rd_req(data_rd_req), .prog_wr_req(prog_wr_req), .data_wr_req(data_wr_req),
    .mem_rdata(mem_rdata), .mem_write_done(mem_write_done));
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one comparison of a value against its expectation
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one Avalon access; held until waitrequest is sampled low at a rising edge,
  // read data taken at that edge, request released right after it
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= {idx, 2'h0};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, wd};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      final_report();
    end else begin
      rdv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic rdchk(input string what, input logic [9:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, exp, rdv);
  endtask
  // poll the control register until the read start bit falls
  task automatic rd_wait();
    int n;
    n = 0;
    do begin
      bus(1'b0, pfa_pkg::IDX_CONTROL, 8'h00);
      n++;
    end while (rdv[0] !== 1'b0 && n < 8);
    chk("read start bit", 32'h0000_0000, 32'(rdv[0]));
  endtask
  // bounded wait for the core stall to reach a level
  task automatic stall_wait(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (core_stall !== lvl && n < 40);
    chk("core_stall", 32'(lvl), 32'(core_stall));
  endtask
  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge core_clk);
    chk("irq", 32'(exp), 32'(irq));
  endtask
  task automatic unlock();
    bus(1'b1, pfa_pkg::IDX_UNLOCK, pfa_pkg::UNLOCK_KEY1);
    bus(1'b1, pfa_pkg::IDX_UNLOCK, pfa_pkg::UNLOCK_KEY2);
  endtask
  // a start attempt that must be turned away
  task automatic refused();
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h86);
    rdchk("status", pfa_pkg::IDX_IRQ_STATUS, 32'h0000_0004);
    irq_chk(1'b1);
    bus(1'b1, pfa_pkg::IDX_IRQ_CLEAR, 8'h07);
    irq_chk(1'b0);
  endtask
  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    core_irq_entry = 1'b0;
    program_write_protect_cfg = 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rdchk("control", pfa_pkg::IDX_CONTROL, 32'h0000_0000);
    rdchk("unlock port", pfa_pkg::IDX_UNLOCK, 32'h0000_0000);
    rdchk("unmapped", 10'h100, 32'h0000_0000);
    bus(1'b1, pfa_pkg::IDX_IRQ_ENABLE, 8'h04);
    rdchk("enable", pfa_pkg::IDX_IRQ_ENABLE, 32'h0000_0004);
    bus(1'b1, pfa_pkg::IDX_ADDR_HIGH, 8'h00);
    bus(1'b1, pfa_pkg::IDX_ADDR_LOW, 8'h05);
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h81);
    rd_wait();
    rdchk("data low", pfa_pkg::IDX_DATA_LOW, 32'h0000_0055);
    rdchk("data high", pfa_pkg::IDX_DATA_HIGH, 32'h0000_003a);
    rdchk("status", pfa_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    irq_chk(1'b0);
    bus(1'b1, pfa_pkg::IDX_IRQ_CLEAR, 8'h07);
    // data-space read through the same registers
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h01);
    rd_wait();
    rdchk("data low", pfa_pkg::IDX_DATA_LOW, 32'h0000_00cd);
    bus(1'b1, pfa_pkg::IDX_DATA_LOW, 8'h77);
    rdchk("data low", pfa_pkg::IDX_DATA_LOW, 32'h0000_0077);
    rdchk("data high", pfa_pkg::IDX_DATA_HIGH, 32'h0000_000b);
    bus(1'b1, pfa_pkg::IDX_IRQ_CLEAR, 8'h07);
    unlock();
    refused();
    // guarded program write of index seven
    bus(1'b1, pfa_pkg::IDX_DATA_LOW, 8'h3c);
    bus(1'b1, pfa_pkg::IDX_DATA_HIGH, 8'h12);
    bus(1'b1, pfa_pkg::IDX_ADDR_LOW, 8'h07);
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h84);
    unlock();
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h86);
    stall_wait(1'b1);
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h80);
    stall_wait(1'b0);
    rdchk("control", pfa_pkg::IDX_CONTROL, 32'h0000_0080);
    rdchk("status", pfa_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h81);
    rd_wait();
    rdchk("data low", pfa_pkg::IDX_DATA_LOW, 32'h0000_003c);
    rdchk("data high", pfa_pkg::IDX_DATA_HIGH, 32'h0000_0012);
    bus(1'b1, pfa_pkg::IDX_IRQ_CLEAR, 8'h07);
    // data-space write: core keeps running, done still reported
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h04);
    unlock();
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h06);
    repeat (4) @(negedge core_clk);
    chk("core_stall", 32'h0000_0000, 32'(core_stall));
    repeat (12) @(posedge core_clk);
    rdchk("status", pfa_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
    rdchk("control", pfa_pkg::IDX_CONTROL, 32'h0000_0004);
    bus(1'b1, pfa_pkg::IDX_IRQ_CLEAR, 8'h07);
    // unlock broken by an interrupt entry
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h84);
    bus(1'b1, pfa_pkg::IDX_UNLOCK, pfa_pkg::UNLOCK_KEY1);
    @(posedge core_clk);
    core_irq_entry <= 1'b1;
    @(posedge core_clk);
    core_irq_entry <= 1'b0;
    bus(1'b1, pfa_pkg::IDX_UNLOCK, pfa_pkg::UNLOCK_KEY2);
    refused();
    // write protect strap cleared
    @(posedge core_clk);
    program_write_protect_cfg <= 1'b0;
    repeat (4) @(posedge core_clk);
    unlock();
    refused();
    @(posedge core_clk);
    program_write_protect_cfg <= 1'b1;
    repeat (4) @(posedge core_clk);
    // reset in mid-write leaves the error flag
    unlock();
    bus(1'b1, pfa_pkg::IDX_CONTROL, 8'h86);
    stall_wait(1'b1);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rdchk("control", pfa_pkg::IDX_CONTROL, 32'h0000_0008);
    chk("core_stall", 32'h0000_0000, 32'(core_stall));
    final_report();
  end
endmodule
